// ==== spc_sdram_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module spc_sdram_ctrl import spc_pkg::*; #(
   parameter int COL_W = 8
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Command pins, sampled on the shared clock
   input  wire logic              cke,
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              ba,
   // Data pins
   input  wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe,
   // Mode settings held by the mode register logic
   input  wire logic [1:0]        cfg_cas_lat,
   input  wire logic [2:0]        cfg_burst_len,
   // Status
   output logic                   power_down,
   output logic                   suspended,
   output logic [N_BANK-1:0]      bank_open,
   output logic                   wr_fifo_ready
);
   localparam int MAW = COL_W + 1;
   localparam int FW  = MAW + DATA_W;
   // Limitations: rows are not stored, so each bank holds a single page of
   // words. A read of a word still queued in the write FIFO returns the older
   // contents; the FIFO lets a read beat take the one array port first, at
   // the price of one cycle, plus one per read beat in between, before written data lands.

   typedef struct packed {
      logic                   cke_q;
      spc_mode_t              mode;
      logic                   bank;
      logic [COL_W-1:0]       col;
      logic [COL_W:0]         left;
      logic                   full;
      logic                   ap;
      logic [1:0]             pv;
      logic [1:0][DATA_W-1:0] pd;
      logic                   ov;
      logic [DATA_W-1:0]      od;
   } spc_state_t;

   localparam spc_state_t ST_RST = '{cke_q: CKE_RST, mode: ST_IDLE, default: '0};

   spc_state_t s_r, s_nxt;
   logic [DATA_W-1:0] mem [2**MAW];

   // ==========================================================
   // Command decode
   logic             frz;
   logic             cmd_v;
   logic [2:0]       cmd;
   logic             is_act, is_rd, is_wr, is_pre, is_bst, is_new, stop;
   logic [COL_W:0]   blen;
   logic [COL_W-1:0] mask;
   logic             cfg_full;

   // One clock of lag on the gate input: the registered copy rules this edge
   assign frz   = ~s_r.cke_q;
   assign cmd   = {ras_n, cas_n, we_n};
   // Nothing but the gate input is looked at while powered down
   assign cmd_v = ~cs_n & ~frz & (s_r.mode != ST_PDN);
   assign is_act = cmd_v & (cmd == CMD_ACT);
   assign is_rd  = cmd_v & (cmd == CMD_READ);
   assign is_wr  = cmd_v & (cmd == CMD_WRITE);
   assign is_pre = cmd_v & (cmd == CMD_PRE);
   assign is_bst = cmd_v & (cmd == CMD_BST);
   assign is_new = is_rd | is_wr;
   assign stop   = is_pre | is_bst;
   assign cfg_full = (cfg_burst_len == BL_FULL);

   // Burst length and wrap mask; full page wraps on the whole column
   always_comb begin
      blen = (COL_W+1)'(1) << cfg_burst_len[1:0];
      if (cfg_full) blen = '0;
      mask = cfg_full ? '1 : COL_W'(blen - 1'b1);
   end

   // ==========================================================
   // Beat selection: a new command restarts, else the burst carries on
   logic             beat_on, last, brd, bap, bbank, bfull;
   logic [COL_W-1:0] bcol;
   logic [COL_W:0]   bleft;
   logic             active;

   assign active = (s_r.mode == ST_RD) | (s_r.mode == ST_WR);

   always_comb begin
      if (is_new) begin
         bcol  = addr[COL_W-1:0];
         bbank = ba;
         bleft = blen;
         bfull = cfg_full;
         bap   = addr[AP_BIT];
         brd   = is_rd;
      end else begin
         bcol  = s_r.col;
         bbank = s_r.bank;
         bleft = s_r.left;
         bfull = s_r.full;
         bap   = s_r.ap;
         brd   = (s_r.mode == ST_RD);
      end
   end

   // A stop in this cycle means this cycle's beat is not taken
   assign beat_on = is_new | (~frz & active & ~stop);
   assign last    = beat_on & ~bfull & (bleft == (COL_W+1)'(1));

   // ==========================================================
   // Write data path through the FIFO into the array
   logic           push, f_valid, f_ready;
   logic [FW-1:0]  f_data;
   logic [MAW-1:0] rd_idx;

   assign push   = beat_on & ~brd;
   assign rd_idx = {bbank, bcol};
   // The array has one port; a read beat stalls the drain for a cycle
   assign f_ready = ~(beat_on & brd);

   spc_fifo #(
      .W (FW),
      .D (FIFO_D)
   ) u_wfifo (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .in_valid  (push),
      .in_ready  (wr_fifo_ready),
      .in_data   ({bbank, bcol, dq_in}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // Drained words land in the array
   always_ff @(posedge clk_sys) begin
      if (f_valid & f_ready) mem[f_data[FW-1:DATA_W]] <= f_data[DATA_W-1:0];
   end

   // ==========================================================
   // Burst and power state
   always_comb begin
      s_nxt       = s_r;
      s_nxt.cke_q = cke;
      case (s_r.mode)
         ST_PDN: begin
            if (!frz) s_nxt.mode = ST_IDLE;
         end
         ST_IDLE, ST_RD, ST_WR: begin
            if (frz && s_r.mode == ST_IDLE) begin
               s_nxt.mode = ST_PDN;
            end else if (beat_on) begin
               s_nxt.bank = bbank;
               s_nxt.col  = (bcol & ~mask) | ((bcol + 1'b1) & mask);
               s_nxt.left = bleft - 1'b1;
               s_nxt.full = bfull;
               s_nxt.ap   = bap;
               s_nxt.mode = last ? ST_IDLE : (brd ? ST_RD : ST_WR);
            end else if (stop) begin
               s_nxt.mode = ST_IDLE;
            end
         end
         default: s_nxt.mode = ST_IDLE;
      endcase
      // Read pipeline holds still while the clock is suspended
      if (!frz) begin
         s_nxt.pv[0] = beat_on & brd;
         s_nxt.pd[0] = mem[rd_idx];
         s_nxt.pv[1] = s_r.pv[0];
         s_nxt.pd[1] = s_r.pd[0];
         s_nxt.ov    = (cfg_cas_lat == CL_TWO) ? s_r.pv[0] : s_r.pv[1];
         // Data holds its last word between bursts
         if (s_nxt.ov) s_nxt.od = (cfg_cas_lat == CL_TWO) ? s_r.pd[0] : s_r.pd[1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) s_r <= ST_RST;
      else       s_r <= s_nxt;
   end

   // ==========================================================
   // Per-bank row state and precharge timing
   logic [N_BANK-1:0] pre_b, arm_b, act_b, busy_b;

   generate
      for (genvar i = 0; i < N_BANK; i++) begin : g_bank
         // Read auto precharge fires at the last beat's issue edge, which is
         // CL-1 clocks before the last word is on the pins
         assign pre_b[i] = (is_pre & (addr[AP_BIT] | (ba == 1'(i))))
                         | (last & brd & bap & (bbank == 1'(i)));
         assign arm_b[i] = last & ~brd & bap & (bbank == 1'(i));
         assign act_b[i] = is_act & (ba == 1'(i));
         spc_bank #(
            .ROW_W (ADDR_W),
            .RP    (RP_CYC),
            .WR    (WR_CYC)
         ) u_bank (
            .clk_sys   (clk_sys),
            .reset     (reset),
            .activate  (act_b[i]),
            .row_in    (addr),
            .pre_now   (pre_b[i]),
            .wr_ap_arm (arm_b[i]),
            .is_open   (bank_open[i]),
            .busy      (busy_b[i]),
            .row_out   ()
         );
      end
   endgenerate

   // ==========================================================
   // Outputs
   assign dq_out     = s_r.od;
   assign dq_oe      = s_r.ov;
   assign power_down = (s_r.mode == ST_PDN);
   assign suspended  = frz & active;

   // ==========================================================
   property p_freeze;
      @(posedge clk_sys) disable iff (reset)
      !s_r.cke_q && active |=> $stable(s_r.col) && $stable(s_r.left) && $stable(dq_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("burst moved while frozen");

   property p_pdn_exit;
      @(posedge clk_sys) disable iff (reset)
      power_down && cke && !s_r.cke_q |=> power_down ##1 !power_down;
   endproperty
   a_pdn_exit: assert property (p_pdn_exit) else $error("power down exit not one clock");

   property p_pdn_deaf;
      @(posedge clk_sys) disable iff (reset)
      power_down && !cs_n |=> $stable(bank_open) && !dq_oe;
   endproperty
   a_pdn_deaf: assert property (p_pdn_deaf) else $error("input taken in power down");

   property p_rd_ap;
      @(posedge clk_sys) disable iff (reset)
      is_rd && addr[AP_BIT] && cfg_burst_len == 3'h1 && !ba && cfg_cas_lat == CL_TWO
         ##1 !is_new && !stop && !is_act && !frz
         |=> !bank_open[0] && dq_oe;
   endproperty
   a_rd_ap: assert property (p_rd_ap) else $error("read auto precharge timing");

   property p_pre_all;
      @(posedge clk_sys) disable iff (reset)
      is_pre && addr[AP_BIT] |=> bank_open == '0 && !active;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank");

   property p_pre_one;
      @(posedge clk_sys) disable iff (reset)
      is_pre && !addr[AP_BIT] && ba && bank_open[0] && !(last && bap)
         |=> bank_open[0] && !bank_open[1];
   endproperty
   a_pre_one: assert property (p_pre_one) else $error("single bank precharge wrong");

   property p_bst;
      @(posedge clk_sys) disable iff (reset)
      is_bst && active && !is_new |=> !active && bank_open == $past(bank_open);
   endproperty
   a_bst: assert property (p_bst) else $error("burst stop closed a row");

   property p_bst_wr;
      @(posedge clk_sys) disable iff (reset)
      is_bst && s_r.mode == ST_WR |-> !push;
   endproperty
   a_bst_wr: assert property (p_bst_wr) else $error("word after stop stored");

   property p_restart;
      @(posedge clk_sys) disable iff (reset)
      is_new && active && !cfg_full && cfg_burst_len == 3'h3
         |=> s_r.left == (COL_W+1)'(7) && s_r.col == $past(addr[COL_W-1:0]) + 1'b1
             || s_r.col[2:0] == 3'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("interrupt did not restart");

   // Every write beat finds room; a dropped beat would lose data silently
   property p_fifo_room;
      @(posedge clk_sys) disable iff (reset)
      push |-> wr_fifo_ready;
   endproperty
   a_fifo_room: assert property (p_fifo_room) else $error("write beat found fifo full");

   // Precharge all starts the row precharge timer in both banks
   property p_pre_busy;
      @(posedge clk_sys) disable iff (reset)
      is_pre && addr[AP_BIT] |=> busy_b == '1;
   endproperty
   a_pre_busy: assert property (p_pre_busy) else $error("precharge all missed a bank");

   // An idle device with the gate low sleeps one clock later
   property p_pdn_enter;
      @(posedge clk_sys) disable iff (reset)
      s_r.mode == ST_IDLE && !s_r.cke_q |=> power_down;
   endproperty
   a_pdn_enter: assert property (p_pdn_enter) else $error("power down entry late");

   // Longer latency: the bank closes two clocks ahead of the last word
   property p_rd_ap3;
      @(posedge clk_sys) disable iff (reset)
      is_rd && addr[AP_BIT] && cfg_burst_len == 3'h1 && !ba && cfg_cas_lat != CL_TWO
         ##1 !is_new && !stop && !is_act && !frz ##1 !frz
         |-> !bank_open[0] ##1 dq_oe;
   endproperty
   a_rd_ap3: assert property (p_rd_ap3) else $error("latency 3 auto close late");

   // A frozen clock leaves the drive enable where it was
   property p_oe_frozen;
      @(posedge clk_sys) disable iff (reset)
      !s_r.cke_q |=> $stable(dq_oe);
   endproperty
   a_oe_frozen: assert property (p_oe_frozen) else $error("drive changed while frozen");

   // The close request rides with the column of every read or write
   property p_new_ap;
      @(posedge clk_sys) disable iff (reset)
      is_new |=> s_r.ap == $past(addr[AP_BIT]);
   endproperty
   a_new_ap: assert property (p_new_ap) else $error("close request not taken");

   // Any precharge ends the burst at its own edge
   property p_pre_end;
      @(posedge clk_sys) disable iff (reset)
      is_pre |=> !active;
   endproperty
   a_pre_end: assert property (p_pre_end) else $error("precharge left burst running");
endmodule : spc_sdram_ctrl
`default_nettype wire

// ==== spc_pkg.sv ====
package spc_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_MHZ = 50;
   localparam int T_RP_NS = 15;
   localparam int T_WR_NS = 15;
   localparam int RP_CYC  = (T_RP_NS * CLK_MHZ + 999) / 1000;
   localparam int WR_CYC  = (T_WR_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W   = 4;
   // ==========================================================
   // Pins and fields
   localparam int ADDR_W  = 11;
   localparam int DATA_W  = 16;
   localparam int AP_BIT  = 10;
   localparam int N_BANK  = 2;
   localparam int FIFO_D  = 4;
   // ==========================================================
   // Commands as {row, column, write} strobes
   localparam logic [2:0] CMD_ACT   = 3'h3;
   localparam logic [2:0] CMD_READ  = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_PRE   = 3'h2;
   localparam logic [2:0] CMD_BST   = 3'h6;
   // Burst length code for full page, latency code for CL2
   localparam logic [2:0] BL_FULL   = 3'h7;
   localparam logic [1:0] CL_TWO    = 2'h2;
   localparam logic       CKE_RST   = 1'h1;
   typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_PDN} spc_mode_t;
endpackage : spc_pkg

// ==== spc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module spc_fifo import spc_pkg::*; #(
   parameter int W = 24,
   parameter int D = FIFO_D
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset,
   // Filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0]       wp;
      logic [PW-1:0]       rp;
      logic [PW:0]         cnt;
   } spc_fifo_t;
   spc_fifo_t s_r, s_nxt;
   logic push, pop;

   // ==========================================================
   // Flags come straight from the count, so full and empty stay honest
   assign in_ready  = (s_r.cnt != (PW+1)'(D));
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer wrap assumes a power-of-two depth
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp          = s_r.wp + 1'b1;
      end
      if (pop) s_nxt.rp = s_r.rp + 1'b1;
      s_nxt.cnt = s_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   end

   always_ff @(posedge clk_sys) begin
      if (reset) s_r <= '0;
      else       s_r <= s_nxt;
   end
endmodule : spc_fifo
`default_nettype wire

// ==== spc_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module spc_bank import spc_pkg::*; #(
   parameter int ROW_W = ADDR_W,
   parameter int RP    = RP_CYC,
   parameter int WR    = WR_CYC
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   // Bank requests
   input  wire logic             activate,
   input  wire logic [ROW_W-1:0] row_in,
   input  wire logic             pre_now,
   input  wire logic             wr_ap_arm,
   // Bank status
   output logic                  is_open,
   output logic                  busy,
   output logic [ROW_W-1:0]      row_out
);
   // The countdown closes the row WR edges after arming; the check window
   // already spans two of them
   localparam int WRD = WR - 1;
   typedef struct packed {
      logic             open;
      logic [ROW_W-1:0] row;
      logic [CNT_W-1:0] rp;
      logic [CNT_W-1:0] wr;
      logic             warm;
   } spc_bank_t;
   spc_bank_t s_r, s_nxt;

   // ==========================================================
   // Row state, precharge timer and write recovery countdown
   always_comb begin
      s_nxt = s_r;
      if (s_r.rp != '0) s_nxt.rp = s_r.rp - 1'b1;
      if (s_r.warm) begin
         if (s_r.wr == CNT_W'(1)) begin
            s_nxt.warm = 1'b0;
            s_nxt.open = 1'b0;
            s_nxt.rp   = CNT_W'(RP);
         end else begin
            s_nxt.wr = s_r.wr - 1'b1;
         end
      end
      // An explicit precharge overrides a pending recovery count
      if (pre_now) begin
         s_nxt.open = 1'b0;
         s_nxt.warm = 1'b0;
         s_nxt.rp   = CNT_W'(RP);
      end else if (wr_ap_arm) begin
         s_nxt.warm = 1'b1;
         s_nxt.wr   = CNT_W'(WR);
      end
      if (activate) begin
         s_nxt.open = 1'b1;
         s_nxt.row  = row_in;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) s_r <= '0;
      else       s_r <= s_nxt;
   end

   assign is_open = s_r.open;
   assign busy    = (s_r.rp != '0);
   assign row_out = s_r.row;

   // ==========================================================
   property p_wr_ap;
      @(posedge clk_sys) disable iff (reset)
      (wr_ap_arm && !pre_now && !activate) ##1 (!activate && !wr_ap_arm)[*2]
         |-> ##WRD !is_open;
   endproperty
   a_wr_ap: assert property (p_wr_ap) else $error("write auto precharge late");

   property p_pre_close;
      @(posedge clk_sys) disable iff (reset)
      pre_now && !activate |=> !is_open && busy;
   endproperty
   a_pre_close: assert property (p_pre_close) else $error("precharge left bank open");
endmodule : spc_bank
`default_nettype wire

// ==== spc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side of the command bus: a controller driving pins at falling edges
module spc_host import spc_pkg::*; (
   // Clock
   input  wire logic         clk_sys,
   // Command pins
   output logic              cke,
   output logic              cs_n,
   output logic              ras_n,
   output logic              cas_n,
   output logic              we_n,
   output logic [ADDR_W-1:0] addr,
   output logic              ba,
   // Write data
   output logic [DATA_W-1:0] dq_in
);
   // ==========================================================
   // Idle bus from time zero
   initial begin
      cke = CKE_RST;
      cs_n = 1'h1;
      {ras_n, cas_n, we_n} = 3'h7;
      addr = '0;
      ba = 1'h0;
      dq_in = '0;
   end
   // ==========================================================
   // One slot: pins change at the falling edge, held over the rising edge
   task automatic slot(input logic sel, input logic [2:0] c,
                       input logic [ADDR_W-1:0] a, input logic b,
                       input logic [DATA_W-1:0] d);
      @(negedge clk_sys);
      cs_n = ~sel;
      {ras_n, cas_n, we_n} = c;
      addr = a;
      ba = b;
      dq_in = d;
   endtask : slot
   // Idle slot; unused lines flip so a stale value is never trusted
   task automatic nop();
      slot(1'h0, 3'h7, ~addr, ~ba, ~dq_in);
   endtask : nop
   // Write beat following a write command
   task automatic beat(input logic [DATA_W-1:0] d);
      slot(1'h0, 3'h7, ~addr, ~ba, d);
   endtask : beat
   // Clock gate change, taken at the next rising edge
   task automatic gate(input logic v);
      cke = v;
   endtask : gate
   // ==========================================================
   // Power down only once every bank is closed and row precharge is over
   task automatic sleep();
      slot(1'h1, CMD_PRE, ADDR_W'(1) << AP_BIT, 1'h0, ~dq_in);
      repeat (RP_CYC + 1) nop();
      gate(1'h0);
   endtask : sleep
   // Leave after a few cycles, far inside the refresh period
   task automatic wake();
      nop();
      gate(1'h1);
   endtask : wake
endmodule : spc_host
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import spc_pkg::*;;
   // ==========================================================
   // Signals
   logic              clk_sys = 1'h0;
   logic              reset = 1'h1;
   logic              cke, cs_n, ras_n, cas_n, we_n, ba;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_in, dq_out;
   logic              dq_oe, power_down, suspended, wr_fifo_ready;
   logic [1:0]        cfg_cas_lat = CL_TWO;
   logic [2:0]        cfg_burst_len = 3'h1;
   logic [N_BANK-1:0] bank_open;
   logic [DATA_W-1:0] wa [8], wb [8], ex [8];
   int                miscompares = 0, checks = 0, cycles = 0;
   localparam logic [ADDR_W-1:0] AP = ADDR_W'(1) << AP_BIT;

   always #10 clk_sys = ~clk_sys;

   spc_sdram_ctrl i_spc_sdram_ctrl (.clk_sys, .reset, .cke, .cs_n, .ras_n, .cas_n,
      .we_n, .addr, .ba, .dq_in, .dq_out, .dq_oe, .cfg_cas_lat, .cfg_burst_len,
      .power_down, .suspended, .bank_open, .wr_fifo_ready);
   spc_host i_spc_host (.clk_sys, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .ba, .dq_in);

   // ==========================================================
   // Compares and verdict
   task automatic c_flag(input logic g, input logic e, input string m);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : c_flag
   task automatic c_word(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e,
                         input string m);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t %s %h %h", $time, m, g, e);
      end
   endtask : c_word
   task automatic c_bank(input logic [N_BANK-1:0] g, input logic [N_BANK-1:0] e,
                         input string m);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t %s %b", $time, m, g);
      end
   endtask : c_bank
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   // A hang is cut short far beyond the roughly 150 cycles the run needs
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end

   // ==========================================================
   // Bus helpers
   task automatic idle(input int n);
      repeat (n) i_spc_host.nop();
   endtask : idle
   task automatic act(input logic b);
      i_spc_host.slot(1'h1, CMD_ACT, 11'h005, b, ~dq_in);
   endtask : act
   // Settings only change under reset, since the design takes them as static
   task automatic restart(input logic [1:0] cl, input logic [2:0] bl);
      @(negedge clk_sys);
      reset = 1'h1;
      cfg_cas_lat = cl;
      cfg_burst_len = bl;
      repeat (2) @(negedge clk_sys);
      reset = 1'h0;
   endtask : restart
   task automatic wr(input logic [ADDR_W-1:0] a, input int n, input logic stop,
                     input logic [DATA_W-1:0] w [8]);
      i_spc_host.slot(1'h1, CMD_WRITE, a, 1'h0, w[0]);
      for (int k = 1; k < n; k++)
         i_spc_host.beat(w[k]);
      if (stop)
         i_spc_host.slot(1'h1, CMD_BST, a, 1'h0, w[n]);
   endtask : wr
   // Read of n words against ex; a stop ends the burst right after word n
   task automatic rd(input logic [ADDR_W-1:0] a, input int n, input logic stop);
      int cl;
      cl = (cfg_cas_lat == CL_TWO) ? 2 : 3;
      i_spc_host.slot(1'h1, CMD_READ, a, 1'h0, ~dq_in);
      for (int k = 1; k <= cl + n; k++) begin
         if (k == n && stop)
            i_spc_host.slot(1'h1, CMD_BST, a, 1'h0, ~dq_in);
         else
            i_spc_host.nop();
         if (k >= cl && k < cl + n)
            c_word(dq_out, ex[k - cl], "read word");
         c_flag(dq_oe, k >= cl && k < cl + n, "read drive");
         if (a[AP_BIT] && (k == n - 1 || k == n))
            c_flag(bank_open[0], k < n, "read auto close");
      end
   endtask : rd

   // ==========================================================
   // Scenarios
   task automatic t_base();
      restart(CL_TWO, 3'h1);
      c_bank(bank_open, 2'h0, "reset banks");
      c_flag(wr_fifo_ready, 1'h1, "reset fifo");
      c_word(dq_out, '0, "reset data");
      act(1'h0);
      act(1'h1);
      idle(1);
      c_bank(bank_open, 2'h3, "activate");
      wr(11'h010, 2, 1'h0, wa);
      idle(4);
      c_bank(bank_open, 2'h3, "row kept");
      ex = wa;
      rd(11'h010, 2, 1'h0);
      ex[0] = wa[1];
      ex[1] = wa[0];
      rd(11'h011, 2, 1'h0);
      i_spc_host.slot(1'h1, CMD_PRE, 11'h000, 1'h1, ~dq_in);
      idle(1);
      c_bank(bank_open, 2'h1, "one bank");
      act(1'h1);
      i_spc_host.slot(1'h1, CMD_PRE, AP, 1'h0, ~dq_in);
      idle(1);
      c_bank(bank_open, 2'h0, "all banks");
   endtask : t_base
   // Both latencies: write and read with automatic close
   task automatic t_auto();
      for (int i = 0; i < 2; i++) begin
         restart(i ? 2'h3 : CL_TWO, 3'h1);
         act(1'h0);
         wr(AP | 11'h020, 2, 1'h0, wb);
         idle(WR_CYC);
         c_flag(bank_open[0], 1'h1, "write recovery");
         idle(1);
         c_flag(bank_open[0], 1'h0, "write auto close");
         idle(4);
         act(1'h0);
         idle(1);
         ex = wb;
         rd(AP | 11'h020, 2, 1'h0);
      end
   endtask : t_auto
   // A read one slot into a write of eight restarts the burst at full length;
   // a read cut by a read would still drain its first word onto the pins
   task automatic t_cut();
      restart(CL_TWO, 3'h3);
      act(1'h0);
      wr(11'h030, 2, 1'h1, wa);
      idle(4);
      i_spc_host.slot(1'h1, CMD_WRITE, 11'h020, 1'h0, wb[0]);
      ex = wa;
      rd(11'h030, 2, 1'h1);
   endtask : t_cut
   // Full page: stops, clock suspend, precharge mid burst
   task automatic t_page();
      restart(CL_TWO, BL_FULL);
      act(1'h0);
      idle(1);
      wr(11'h050, 6, 1'h1, wb);
      idle(4);
      wr(11'h050, 4, 1'h1, wa);
      idle(4);
      c_flag(bank_open[0], 1'h1, "stop keeps row");
      ex = wa;
      ex[4] = wb[4];
      ex[5] = wb[5];
      rd(11'h050, 6, 1'h1);
      i_spc_host.slot(1'h1, CMD_READ, 11'h050, 1'h0, ~dq_in);
      idle(3);
      i_spc_host.gate(1'h0);
      idle(1);
      c_flag(suspended, 1'h1, "suspend entry");
      idle(1);
      i_spc_host.gate(1'h1);
      idle(1);
      c_word(dq_out, ex[2], "word stretched");
      idle(1);
      c_word(dq_out, ex[3], "no word skipped");
      c_flag(suspended, 1'h0, "suspend exit");
      i_spc_host.slot(1'h1, CMD_READ, 11'h050, 1'h0, ~dq_in);
      idle(1);
      i_spc_host.slot(1'h1, CMD_PRE, 11'h000, 1'h0, ~dq_in);
      idle(1);
      c_flag(bank_open[0], 1'h0, "precharge closes");
      idle(2);
      c_flag(dq_oe, 1'h0, "precharge ends burst");
   endtask : t_page
   task automatic t_power();
      i_spc_host.sleep();
      idle(1);
      c_flag(power_down, 1'h0, "entry latency");
      idle(1);
      c_flag(power_down, 1'h1, "power down");
      act(1'h0);
      idle(2);
      c_bank(bank_open, 2'h0, "inputs ignored");
      i_spc_host.wake();
      idle(1);
      c_flag(power_down, 1'h1, "exit latency");
      idle(1);
      c_flag(power_down, 1'h0, "awake");
      act(1'h0);
      idle(1);
      c_bank(bank_open, 2'h1, "awake activate");
   endtask : t_power

   // ==========================================================
   // Main sequence
   initial begin
      for (int i = 0; i < 8; i++) begin
         wa[i] = 16'hA5C0 + 16'(i);
         wb[i] = 16'h3E10 + 16'(i);
      end
      ex = wa;
      repeat (8) @(negedge clk_sys);
      reset = 1'h0;
      t_base();
      t_auto();
      t_cut();
      t_page();
      t_power();
      close_out();
   end
endmodule : tb
`default_nettype wire
